// ---- fca_map.svh ----
// object indexes, field positions and reset values of the fault clear and alarm mask bank
`ifndef FCA_MAP_SVH
`define FCA_MAP_SVH

`define FCA_IDX_FAULT_CLEAR 16'h5000
`define FCA_IDX_ALARM_MASK 16'h5001
`define FCA_IDX_SLOT_CODES 16'h5002
`define FCA_SUB_ZERO 8'h00
`define FCA_SUB_FIRST 8'h01
`define FCA_SUB_LAST 8'h09
`define FCA_SLOT_NUM 8'h09
`define FCA_SLOT_LAST 4'h8
`define FCA_SLOT_FIRST 4'h0
`define FCA_SLOT_EMPTY 8'h00
`define FCA_WORD_RESET 16'h0000
`define FCA_ALL_ONES 16'hffff
`define FCA_BUS_ERR_MASK 16'h00f0
`define FCA_DEFAULTS_EVENTS 16'h8200
`define FCA_ZERO_BYTE 8'h00
`define FCA_SETTLE_ZERO 4'h0
`define FCA_SETTLE_MIN 4'ha
`define FCA_SETTLE_MAX 4'hf

`endif

// ---- fca_pkg.sv ----
// types shared by the fault clear and alarm mask bank
package fca_pkg;
    typedef logic [15:0] fca_word_t;
    typedef logic [7:0] fca_code_t;
    typedef logic [3:0] fca_slot_t;
    typedef enum logic {
        FCA_RESP_OK,
        FCA_RESP_ABORT
    } fca_resp_t;
endpackage : fca_pkg

// ---- fca_flag_cell.sv ----
// one sticky fault flag, set dominant over clear
`timescale 1ns/100ps
module fca_flag_cell (
    input wire logic clock_in,
    input wire logic rst_in,
    input wire logic set_in,
    input wire logic clear_in,
    output logic flag_out
);
    logic flag_q;
    logic flag_d;

    // an event in the clearing cycle must not be lost
    always_comb begin
        flag_d = set_in | (flag_q & ~clear_in);
    end

    always_ff @(posedge clock_in) begin
        if (rst_in) begin
            flag_q <= 1'b0;
        end else begin
            flag_q <= flag_d;
        end
    end

    assign flag_out = flag_q;
endmodule : fca_flag_cell

// ---- fca_slot_mem.sv ----
// small memory of slot module codes, registered read port
`timescale 1ns/100ps
module fca_slot_mem #(
    parameter int SLOTS = 9,
    parameter int AW = 4,
    parameter int DW = 8
) (
    input wire logic clock_in,
    input wire logic wr_en_in,
    input wire logic [AW-1:0] wr_addr_in,
    input wire logic [DW-1:0] wr_data_in,
    input wire logic [AW-1:0] rd_addr_in,
    output logic [DW-1:0] rd_data_out
);
    logic [DW-1:0] mem_q [SLOTS];
    logic [DW-1:0] rd_data_q;

    always_ff @(posedge clock_in) begin
        if (wr_en_in) begin
            mem_q[wr_addr_in] <= wr_data_in;
        end
        rd_data_q <= mem_q[rd_addr_in];
    end

    assign rd_data_out = rd_data_q;
endmodule : fca_slot_mem

// ---- fca_fault_alarm.sv ----
// fault clear word, alarm enable mask, slot module codes and alarm relay drive
`include "fca_map.svh"
`timescale 1ns/100ps
module fca_fault_alarm (
    input wire logic clock_in,
    input wire logic rst_in,
    input wire logic od_read_in,
    input wire logic od_write_in,
    input wire logic [15:0] od_index_in,
    input wire logic [7:0] od_subindex_in,
    input wire logic [15:0] od_wdata_in,
    output logic od_ack_out,
    output logic od_abort_out,
    output logic [15:0] od_rdata_out,
    input wire logic [15:0] fault_event_in,
    input wire logic [71:0] slot_code_in,
    input wire logic [8:0] slot_present_in,
    output logic [15:0] fault_flags_out,
    output logic [15:0] fault_clear_word_out,
    output logic defaults_rewrite_out,
    output logic alarm_relay_out
);
    fca_pkg::fca_word_t fault_clear_q;
    fca_pkg::fca_word_t fault_clear_d;
    fca_pkg::fca_word_t alarm_mask_q;
    fca_pkg::fca_word_t alarm_mask_d;
    fca_pkg::fca_word_t flags;
    fca_pkg::fca_word_t clear_vec;
    fca_pkg::fca_word_t rdata_q;
    fca_pkg::fca_word_t rdata_d;
    fca_pkg::fca_resp_t resp_q;
    fca_pkg::fca_resp_t resp_d;
    fca_pkg::fca_slot_t scan_q;
    fca_pkg::fca_slot_t scan_d;
    fca_pkg::fca_slot_t slot_raddr;
    fca_pkg::fca_code_t scan_code;
    fca_pkg::fca_code_t slot_rdata;
    logic ack_q;
    logic ack_d;
    logic slot_sel_q;
    logic slot_sel_d;
    logic alarm_q;
    logic alarm_d;
    logic rewrite_q;
    logic rewrite_d;
    logic req;
    logic hit_clear;
    logic hit_mask;
    logic hit_slot_count;
    logic hit_slot_code;
    logic wr_clear;
    logic defaults_event;
    logic [8:0] present_q;
    logic [71:0] codes_q;
    fca_pkg::fca_slot_t settle_q;
    fca_pkg::fca_slot_t settle_d;
    fca_pkg::fca_code_t slot_expect;

    // object decode
    always_comb begin
        req = od_read_in | od_write_in;
        hit_clear = (od_index_in == `FCA_IDX_FAULT_CLEAR) && (od_subindex_in == `FCA_SUB_ZERO);
        hit_mask = (od_index_in == `FCA_IDX_ALARM_MASK) && (od_subindex_in == `FCA_SUB_ZERO);
        hit_slot_count = (od_index_in == `FCA_IDX_SLOT_CODES) && (od_subindex_in == `FCA_SUB_ZERO);
        hit_slot_code = (od_index_in == `FCA_IDX_SLOT_CODES) && (od_subindex_in >= `FCA_SUB_FIRST)
            && (od_subindex_in <= `FCA_SUB_LAST);
        wr_clear = od_write_in && hit_clear;
        slot_raddr = 4'(od_subindex_in - `FCA_SUB_FIRST);
    end

    // fault clear word and flags
    // bus error flags only go with the all-ones write
    always_comb begin
        clear_vec = `FCA_WORD_RESET;
        if (wr_clear) begin
            if (od_wdata_in == `FCA_ALL_ONES) begin
                clear_vec = `FCA_ALL_ONES;
            end else begin
                clear_vec = od_wdata_in & ~`FCA_BUS_ERR_MASK;
            end
        end
        fault_clear_d = wr_clear ? od_wdata_in : fault_clear_q;
    end

    genvar gi;
    generate
        for (gi = 0; gi < 16; gi++) begin : g_flag
            fca_flag_cell u_flag (
                .clock_in(clock_in),
                .rst_in(rst_in),
                .set_in(fault_event_in[gi]),
                .clear_in(clear_vec[gi]),
                .flag_out(flags[gi])
            );
        end
    endgenerate

    // alarm mask and relay
    always_comb begin
        defaults_event = |(fault_event_in & `FCA_DEFAULTS_EVENTS);
        alarm_mask_d = alarm_mask_q;
        if (od_write_in && hit_mask) begin
            alarm_mask_d = od_wdata_in;
        end
        // default rewrite beats a simultaneous mask write
        if (defaults_event) begin
            alarm_mask_d = `FCA_WORD_RESET;
        end
        rewrite_d = defaults_event;
        alarm_d = |(flags & alarm_mask_q);
    end

    // slot code scanner
    // one position refreshed per cycle; a change shows within nine cycles
    always_comb begin
        scan_d = (scan_q == `FCA_SLOT_LAST) ? `FCA_SLOT_FIRST : 4'(scan_q + 4'h1);
        scan_code = slot_present_in[scan_q] ? slot_code_in[scan_q*8 +: 8] : `FCA_SLOT_EMPTY;
    end

    // slot reads are exact only once a full sweep has seen unchanged slot inputs
    always_comb begin
        settle_d = (settle_q == `FCA_SETTLE_MAX) ? settle_q : 4'(settle_q + 4'h1);
        if ((slot_present_in != present_q) || (slot_code_in != codes_q)) begin
            settle_d = `FCA_SETTLE_ZERO;
        end
        // expected answer of a slot read, used by the checks only
        slot_expect = `FCA_SLOT_EMPTY;
        if (hit_slot_code && slot_present_in[slot_raddr]) begin
            slot_expect = slot_code_in[slot_raddr*8 +: 8];
        end
    end

    fca_slot_mem #(
        .SLOTS(9),
        .AW(4),
        .DW(8)
    ) u_slot_mem (
        .clock_in(clock_in),
        .wr_en_in(1'b1),
        .wr_addr_in(scan_q),
        .wr_data_in(scan_code),
        .rd_addr_in(slot_raddr),
        .rd_data_out(slot_rdata)
    );

    // access answer
    always_comb begin
        ack_d = req;
        resp_d = fca_pkg::FCA_RESP_OK;
        slot_sel_d = 1'b0;
        rdata_d = `FCA_WORD_RESET;
        if (hit_clear) begin
            rdata_d = fault_clear_q;
        end else if (hit_mask) begin
            rdata_d = alarm_mask_q;
        end else if (hit_slot_count) begin
            rdata_d = {`FCA_ZERO_BYTE, `FCA_SLOT_NUM};
            resp_d = od_write_in ? fca_pkg::FCA_RESP_ABORT : fca_pkg::FCA_RESP_OK;
        end else if (hit_slot_code) begin
            slot_sel_d = od_read_in;
            resp_d = od_write_in ? fca_pkg::FCA_RESP_ABORT : fca_pkg::FCA_RESP_OK;
        end else begin
            resp_d = fca_pkg::FCA_RESP_ABORT;
        end
        if (!req) begin
            resp_d = fca_pkg::FCA_RESP_OK;
            slot_sel_d = 1'b0;
        end
    end

    always_ff @(posedge clock_in) begin
        if (rst_in) begin
            fault_clear_q <= `FCA_WORD_RESET;
            alarm_mask_q <= `FCA_WORD_RESET;
            alarm_q <= 1'b0;
            rewrite_q <= 1'b0;
            scan_q <= `FCA_SLOT_FIRST;
            ack_q <= 1'b0;
            resp_q <= fca_pkg::FCA_RESP_OK;
            slot_sel_q <= 1'b0;
            rdata_q <= `FCA_WORD_RESET;
            present_q <= '0;
            codes_q <= '0;
            settle_q <= `FCA_SETTLE_ZERO;
        end else begin
            fault_clear_q <= fault_clear_d;
            alarm_mask_q <= alarm_mask_d;
            alarm_q <= alarm_d;
            rewrite_q <= rewrite_d;
            scan_q <= scan_d;
            ack_q <= ack_d;
            resp_q <= resp_d;
            slot_sel_q <= slot_sel_d;
            rdata_q <= rdata_d;
            present_q <= slot_present_in;
            codes_q <= slot_code_in;
            settle_q <= settle_d;
        end
    end

    // slot data come straight from the memory output register
    assign od_rdata_out = slot_sel_q ? {`FCA_ZERO_BYTE, slot_rdata} : rdata_q;
    assign od_ack_out = ack_q;
    assign od_abort_out = ack_q && (resp_q == fca_pkg::FCA_RESP_ABORT);
    assign fault_flags_out = flags;
    assign fault_clear_word_out = fault_clear_q;
    assign defaults_rewrite_out = rewrite_q;
    assign alarm_relay_out = alarm_q;

    // checks
    a_clear_word_reset: assert property (@(posedge clock_in)
        $past(rst_in) |-> fault_clear_word_out == `FCA_WORD_RESET)
        else $error("fault clear word not zero after reset");

    a_partial_clear_exact: assert property (@(posedge clock_in) disable iff (rst_in)
        (od_write_in && hit_clear && od_wdata_in != `FCA_ALL_ONES && fault_event_in == `FCA_WORD_RESET)
        |=> flags == ($past(flags) & ~($past(od_wdata_in) & ~`FCA_BUS_ERR_MASK)))
        else $error("partial clear touched wrong flags");

    a_bus_err_kept: assert property (@(posedge clock_in) disable iff (rst_in)
        (od_write_in && hit_clear && od_wdata_in != `FCA_ALL_ONES)
        |=> (flags & `FCA_BUS_ERR_MASK) == (($past(flags) | $past(fault_event_in)) & `FCA_BUS_ERR_MASK))
        else $error("bus error flag cleared without all-ones write");

    a_all_ones_clear: assert property (@(posedge clock_in) disable iff (rst_in)
        (od_write_in && hit_clear && od_wdata_in == `FCA_ALL_ONES)
        |=> flags == $past(fault_event_in))
        else $error("all-ones write did not clear every flag");

    a_flag_latched: assert property (@(posedge clock_in) disable iff (rst_in)
        !wr_clear |=> (flags & $past(flags)) == $past(flags))
        else $error("fault flag dropped without a clear");

    a_alarm_follows: assert property (@(posedge clock_in) disable iff (rst_in)
        ##1 alarm_relay_out == |($past(flags) & $past(alarm_mask_q)))
        else $error("alarm relay does not match enabled flags");

    a_mask_default: assert property (@(posedge clock_in) disable iff (rst_in)
        defaults_event |=> alarm_mask_q == `FCA_WORD_RESET && defaults_rewrite_out)
        else $error("mask not reset on defaults rewrite");

    a_slot_ro_ack: assert property (@(posedge clock_in) disable iff (rst_in)
        (od_write_in && hit_slot_code) |=> od_ack_out && od_abort_out)
        else $error("write to slot code not refused");

    a_empty_slot_zero: assert property (@(posedge clock_in) disable iff (rst_in)
        (od_read_in && hit_slot_code && settle_q >= `FCA_SETTLE_MIN && !slot_present_in[slot_raddr])
        |=> od_rdata_out == `FCA_WORD_RESET)
        else $error("empty slot not read as zero");

    a_slot_read_code: assert property (@(posedge clock_in) disable iff (rst_in)
        (od_read_in && hit_slot_code && settle_q >= `FCA_SETTLE_MIN && slot_present_in[slot_raddr])
        |=> od_rdata_out == {`FCA_ZERO_BYTE, $past(slot_expect)})
        else $error("slot code read from the wrong position");

    a_unmapped_abort: assert property (@(posedge clock_in) disable iff (rst_in)
        (req && !hit_clear && !hit_mask && !hit_slot_count && !hit_slot_code)
        |=> od_ack_out && od_abort_out)
        else $error("unmapped object not refused");

    a_mask_write_lands: assert property (@(posedge clock_in) disable iff (rst_in)
        (od_write_in && hit_mask && !defaults_event)
        |=> alarm_mask_q == $past(od_wdata_in))
        else $error("alarm mask write lost");

    a_clear_word_write: assert property (@(posedge clock_in) disable iff (rst_in)
        wr_clear
        |=> fault_clear_word_out == $past(od_wdata_in))
        else $error("fault clear word does not hold the written value");

    a_set_beats_clear: assert property (@(posedge clock_in) disable iff (rst_in)
        fault_event_in != `FCA_WORD_RESET
        |=> (flags & $past(fault_event_in)) == $past(fault_event_in))
        else $error("fault event lost in a clearing cycle");

    a_clear_word_read: assert property (@(posedge clock_in) disable iff (rst_in)
        (od_read_in && hit_clear)
        |=> od_rdata_out == $past(fault_clear_word_out))
        else $error("fault clear word read back wrong");

    a_slot_count_read: assert property (@(posedge clock_in) disable iff (rst_in)
        (od_read_in && hit_slot_count)
        |=> od_rdata_out == {`FCA_ZERO_BYTE, `FCA_SLOT_NUM} && !od_abort_out)
        else $error("slot count read back wrong");
endmodule : fca_fault_alarm

// ---- fca_od_master.sv ----
// fieldbus master model issuing one object request per call
`timescale 1ns/100ps
module fca_od_master (
    input wire logic clock_in,
    input wire logic ack_in,
    input wire logic abort_in,
    input wire logic [15:0] rdata_in,
    output logic read_out,
    output logic write_out,
    output logic [15:0] index_out,
    output logic [7:0] sub_out,
    output logic [15:0] wdata_out
);
    initial begin
        read_out = 1'b0;
        write_out = 1'b0;
        index_out = 16'h0000;
        sub_out = 8'h00;
        wdata_out = 16'h0000;
    end
    // no ready: taken at the next edge, answer read half a cycle after it
    task automatic access(input logic wr, input logic [15:0] idx, input logic [7:0] sub, input logic [15:0] wd,
                          output logic ack, output logic abort, output logic [15:0] rdata);
        @(negedge clock_in);
        read_out = ~wr;
        write_out = wr;
        index_out = idx;
        sub_out = sub;
        wdata_out = wd;
        @(negedge clock_in);
        ack = ack_in;
        abort = abort_in;
        rdata = rdata_in;
        read_out = 1'b0;
        write_out = 1'b0;
        // released lines must not keep looking like the last request
        index_out = ~idx;
        sub_out = ~sub;
        wdata_out = ~wd;
    endtask : access
endmodule : fca_od_master

// ---- fca_fault_alarm_tb.sv ----
// testbench of the fault clear and alarm mask bank
`timescale 1ns/100ps
`include "fca_map.svh"
module fca_fault_alarm_tb;
    logic clock_in = 1'b0;
    logic rst_in = 1'b1;
    logic rd, wr, ack, abort, relay, dflt, a_ack, a_abort;
    logic [15:0] idx, wd, rdata, flags, cw, a_rdata, m;
    logic [15:0] ev = 16'h0000;
    logic [7:0] sub;
    logic [71:0] codes;
    logic [8:0] present = 9'h1ef;
    int n_mismatch = 0;
    int total_checks = 0;
    int cycles = 0;
    always #12.5 clock_in = ~clock_in;
    fca_fault_alarm u_fca_fault_alarm (.clock_in(clock_in), .rst_in(rst_in), .od_read_in(rd), .od_write_in(wr),
        .od_index_in(idx), .od_subindex_in(sub), .od_wdata_in(wd), .od_ack_out(ack), .od_abort_out(abort),
        .od_rdata_out(rdata), .fault_event_in(ev), .slot_code_in(codes), .slot_present_in(present),
        .fault_flags_out(flags), .fault_clear_word_out(cw), .defaults_rewrite_out(dflt), .alarm_relay_out(relay));
    fca_od_master u_fca_od_master (.clock_in(clock_in), .ack_in(ack), .abort_in(abort), .rdata_in(rdata),
        .read_out(rd), .write_out(wr), .index_out(idx), .sub_out(sub), .wdata_out(wd));
    task automatic chk_word(input string what, input logic [15:0] exp, input logic [15:0] got);
        total_checks++;
        if (got !== exp) begin
            n_mismatch++;
            $display("Error %s expected %h seen %h", what, exp, got);
        end
    endtask : chk_word
    task automatic chk_bit(input string what, input logic exp, input logic got);
        chk_word(what, {15'h0000, exp}, {15'h0000, got});
    endtask : chk_bit
    task automatic od_write(input logic [15:0] i, input logic [7:0] s, input logic [15:0] d, input logic ab);
        u_fca_od_master.access(1'b1, i, s, d, a_ack, a_abort, a_rdata);
        chk_bit("write ack", 1'b1, a_ack);
        chk_bit("write abort", ab, a_abort);
    endtask : od_write
    task automatic od_read(input logic [15:0] i, input logic [7:0] s, input logic [15:0] e, input logic ab);
        u_fca_od_master.access(1'b0, i, s, 16'h0000, a_ack, a_abort, a_rdata);
        chk_bit("read ack", 1'b1, a_ack);
        chk_bit("read abort", ab, a_abort);
        chk_word("read data", e, a_rdata);
    endtask : od_read
    task automatic cyc(input int n);
        repeat (n) @(negedge clock_in);
    endtask : cyc
    task automatic pulse(input logic [15:0] bits);
        @(negedge clock_in);
        ev = bits;
        @(negedge clock_in);
        ev = 16'h0000;
    endtask : pulse
    task automatic summarize();
        if (n_mismatch == 0 && total_checks > 0) begin
            $display("[ PASS ]");
        end else begin
            $display("[ FAIL ]");
        end
        $finish;
    endtask : summarize
    always @(posedge clock_in) begin
        cycles++;
        if (cycles == 3000) begin
            n_mismatch++;
            summarize();
        end
    end
    initial begin
        // module codes are arbitrary values, position 4 (sub-index 5) left empty
        for (int n = 0; n < 9; n++) begin
            codes[8*n +: 8] = 8'h31 + 8'(n);
        end
        repeat (8) @(negedge clock_in);
        rst_in = 1'b0;
        // slot memory is refreshed by a scanner, so give it a full sweep first
        cyc(12);
        chk_word("flags", 16'h0000, flags);
        od_read(`FCA_IDX_FAULT_CLEAR, 8'h00, 16'h0000, 1'b0);
        od_read(`FCA_IDX_ALARM_MASK, 8'h00, 16'h0000, 1'b0);
        od_read(`FCA_IDX_SLOT_CODES, 8'h00, 16'h0009, 1'b0);
        for (int n = 1; n <= 9; n++) begin
            od_read(`FCA_IDX_SLOT_CODES, 8'(n), present[n-1] ? {8'h00, codes[8*(n-1) +: 8]} : 16'h0000, 1'b0);
        end
        od_write(`FCA_IDX_SLOT_CODES, 8'h01, 16'h00ff, 1'b1);
        od_read(16'h5003, 8'h00, 16'h0000, 1'b1);
        od_write(`FCA_IDX_FAULT_CLEAR, 8'h01, 16'hffff, 1'b1);
        pulse(16'hffff);
        cyc(3);
        chk_word("flags", 16'hffff, flags);
        od_write(`FCA_IDX_FAULT_CLEAR, 8'h00, 16'h00f0, 1'b0);
        chk_word("flags", 16'hffff, flags);
        od_write(`FCA_IDX_FAULT_CLEAR, 8'h00, 16'h0f0f, 1'b0);
        chk_word("flags", 16'hf0f0, flags);
        chk_word("clear word", 16'h0f0f, cw);
        od_read(`FCA_IDX_FAULT_CLEAR, 8'h00, 16'h0f0f, 1'b0);
        od_write(`FCA_IDX_FAULT_CLEAR, 8'h00, 16'hfffe, 1'b0);
        chk_word("flags", 16'h00f0, flags);
        od_write(`FCA_IDX_FAULT_CLEAR, 8'h00, 16'hffff, 1'b0);
        chk_word("flags", 16'h0000, flags);
        for (int b = 0; b < 16; b++) begin
            m = 16'h0001 << b;
            od_write(`FCA_IDX_ALARM_MASK, 8'h00, m, 1'b0);
            od_read(`FCA_IDX_ALARM_MASK, 8'h00, m, 1'b0);
            pulse((b == 0) ? 16'h0002 : 16'h0001);
            cyc(2);
            chk_bit("relay unmasked", 1'b0, relay);
            pulse(m);
            chk_bit("defaults pulse", b == 9 || b == 15, dflt);
            cyc(2);
            chk_bit("relay masked", !(b == 9 || b == 15), relay);
            if (b == 9 || b == 15) begin
                od_read(`FCA_IDX_ALARM_MASK, 8'h00, 16'h0000, 1'b0);
            end
            od_write(`FCA_IDX_FAULT_CLEAR, 8'h00, m, 1'b0);
            cyc(1);
            chk_bit("relay single clear", b >= 4 && b <= 7 && !(b == 9 || b == 15), relay);
            od_write(`FCA_IDX_FAULT_CLEAR, 8'h00, 16'hffff, 1'b0);
            cyc(1);
            chk_bit("relay all clear", 1'b0, relay);
        end
        summarize();
    end
endmodule : fca_fault_alarm_tb
